// ---- logic/slss_map.svh ----
`ifndef SLSS_MAP_SVH
`define SLSS_MAP_SVH

`define SLSS_LOCK_EDGES      4096
`define SLSS_CAL_EDGES       180
`define SLSS_REMOTE_SLEEP_OUT_N_EDGES     7
`define SLSS_MCLK_NS         50
`define SLSS_PIX_MAX_PER_NS  500
`define SLSS_STOP_CYC        ((`SLSS_REMOTE_SLEEP_OUT_N_EDGES * `SLSS_PIX_MAX_PER_NS) / `SLSS_MCLK_NS)

`endif

// ---- logic/slss_pkg.sv ----
package slss_pkg;

  typedef enum logic [2:0] {
    SLSS_OFF,
    SLSS_LOCK,
    SLSS_CAL_LOW,
    SLSS_CAL_HIGH,
    SLSS_CAL_FINAL,
    SLSS_ACTIVE
  } slss_state_t;

  typedef struct packed {
    logic clkLevel;
    logic clkEn;
    logic dataEn;
  } slss_line_t;

endpackage

// ---- logic/slss_sync.sv ----
`timescale 1ns/1ps
module slss_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_r;

  // first stage feeds only the second
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stage1_r <= '0;
      syncOut  <= '0;
    end else begin
      stage1_r <= asyncIn;
      syncOut  <= stage1_r;
    end
  end

endmodule

// ---- logic/slss_sequencer.sv ----
// Overview of operation
// - count 4096 pixel edges before start-up
// - link clock low, high, low: 180 each
// - raise remote sleep 7 pixel edges after start
// - drop remote sleep 7 periods after stop
// - reach zero line current within 2 ms
// - active: link clock follows multiplier clock
// - off phase: all line drivers off
`timescale 1ns/1ps
`include "slss_map.svh"
module slss_sequencer #(
  parameter int LOCK_EDGES = `SLSS_LOCK_EDGES,
  parameter int CAL_EDGES  = `SLSS_CAL_EDGES
) (
  input  wire logic           mclk,
  input  wire logic           reset_n,
  input  wire logic           sleep_request_n,
  input  wire logic           pixelClk,
  input  wire logic           multLinkClk,
  output slss_pkg::slss_line_t lineOut,
  output logic                remote_sleep_out_n,
  output logic                pllEnable,
  output logic                linkActive
);
  import slss_pkg::*;

  localparam int STOP_CYC = `SLSS_STOP_CYC;
  localparam int CNT_W    = $clog2(LOCK_EDGES + 1);

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling and edge finding

  logic [2:0]        syncBus;
  logic              sleepSync_n;
  logic              pixSync;
  logic              linkSync;
  logic              pixPrev_r;
  logic              linkPrev_r;

  slss_sync #(.WIDTH(3)) u_sync (
    .mclk    (mclk),
    .reset_n (reset_n),
    .asyncIn ({sleep_request_n, pixelClk, multLinkClk}),
    .syncOut (syncBus)
  );

  assign sleepSync_n = syncBus[2];
  assign pixSync     = syncBus[1];
  assign linkSync    = syncBus[0];

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pixPrev_r  <= 1'b0;
      linkPrev_r <= 1'b0;
    end else begin
      pixPrev_r  <= pixSync;
      linkPrev_r <= linkSync;
    end
  end

  wire pixRise  = pixSync & ~pixPrev_r;
  wire pixEdge  = pixSync ^ pixPrev_r;
  wire linkRise = linkSync & ~linkPrev_r;

  ////////////////////////////////////////////////////////////////////////////
  // pixel clock start and stop detection

  logic [2:0]        startCnt_r;
  logic [6:0]        stallCnt_r;
  logic              pixRun_nxt;

  // stop gap sized for the slowest legal pixel clock, so a slow clock is
  // never mistaken for a stopped one
  // an edge masks the saturated gap, else the first rise after a stop is lost
  wire pixStop  = (stallCnt_r == 7'(STOP_CYC)) && !pixEdge;
  wire pixStart = pixRise && (startCnt_r == 3'(`SLSS_REMOTE_SLEEP_OUT_N_EDGES - 1));

  always_comb begin
    pixRun_nxt = remote_sleep_out_n;
    if (!remote_sleep_out_n && pixStart) begin
      pixRun_nxt = 1'b1;
    end else if (remote_sleep_out_n && pixStop) begin
      pixRun_nxt = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      startCnt_r         <= 3'h0;
      stallCnt_r         <= 7'h00;
      remote_sleep_out_n <= 1'b0;
    end else begin
      remote_sleep_out_n <= pixRun_nxt;
      if (pixEdge) begin
        stallCnt_r <= 7'h00;
      end else if (!pixStop) begin
        stallCnt_r <= stallCnt_r + 7'h01;
      end
      if (pixStop || pixRun_nxt) begin
        startCnt_r <= 3'h0;
      end else if (pixRise) begin
        startCnt_r <= startCnt_r + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // start-up sequencer

  slss_state_t       state_r;
  slss_state_t       state_nxt;
  logic [CNT_W-1:0]  seqCnt_r;
  slss_line_t        line_nxt;

  // a stopped pixel clock also drops the link to its low-power state
  wire goOff     = ~sleepSync_n | ~remote_sleep_out_n;
  wire inLock    = (state_r == SLSS_LOCK);
  wire stepEvt   = inLock ? pixRise : linkRise;
  wire [CNT_W-1:0] stepLast = inLock ? CNT_W'(LOCK_EDGES - 1) : CNT_W'(CAL_EDGES - 1);
  wire advance   = stepEvt && (seqCnt_r == stepLast);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SLSS_OFF:       state_nxt = SLSS_LOCK;
      SLSS_LOCK:      if (advance) state_nxt = SLSS_CAL_LOW;
      SLSS_CAL_LOW:   if (advance) state_nxt = SLSS_CAL_HIGH;
      SLSS_CAL_HIGH:  if (advance) state_nxt = SLSS_CAL_FINAL;
      SLSS_CAL_FINAL: if (advance) state_nxt = SLSS_ACTIVE;
      SLSS_ACTIVE:    state_nxt = SLSS_ACTIVE;
      default:        state_nxt = SLSS_OFF;
    endcase
    if (goOff) begin
      state_nxt = SLSS_OFF;
    end
  end

  always_comb begin
    line_nxt = '0;
    case (state_nxt)
      SLSS_CAL_LOW:   line_nxt = '{clkLevel: 1'b0, clkEn: 1'b1, dataEn: 1'b0};
      SLSS_CAL_HIGH:  line_nxt = '{clkLevel: 1'b1, clkEn: 1'b1, dataEn: 1'b0};
      SLSS_CAL_FINAL: line_nxt = '{clkLevel: 1'b0, clkEn: 1'b1, dataEn: 1'b1};
      SLSS_ACTIVE:    line_nxt = '{clkLevel: linkSync, clkEn: 1'b1, dataEn: 1'b1};
      default:        line_nxt = '0;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_r    <= SLSS_OFF;
      seqCnt_r   <= '0;
      lineOut    <= '0;
      pllEnable  <= 1'b0;
      linkActive <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      lineOut    <= line_nxt;
      pllEnable  <= (state_nxt != SLSS_OFF);
      linkActive <= (state_nxt == SLSS_ACTIVE);
      if (state_nxt != state_r) begin
        seqCnt_r <= '0;
      end else if (stepEvt) begin
        seqCnt_r <= seqCnt_r + CNT_W'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  lock_count_a: assert property (
    (state_r == SLSS_CAL_LOW) && ($past(state_r) == SLSS_LOCK)
      |-> $past(seqCnt_r) == CNT_W'(LOCK_EDGES - 1))
    else $error("left lock wait at wrong count");

  cal_levels_a: assert property (
    ((state_r == SLSS_CAL_HIGH) |-> lineOut.clkLevel && lineOut.clkEn && !lineOut.dataEn)
    and ((state_r == SLSS_CAL_LOW) |-> !lineOut.clkLevel && lineOut.clkEn)
    and ((state_r == SLSS_CAL_FINAL) |-> !lineOut.clkLevel && lineOut.dataEn))
    else $error("calibration line level wrong");

  cal_length_a: assert property (
    (state_r inside {SLSS_CAL_LOW, SLSS_CAL_HIGH, SLSS_CAL_FINAL})
      && (state_nxt != state_r) && !goOff
      |-> linkRise && (seqCnt_r == CNT_W'(CAL_EDGES - 1)))
    else $error("calibration interval length wrong");

  active_clock_a: assert property (
    (state_r == SLSS_ACTIVE) && ($past(state_r) == SLSS_ACTIVE)
      |-> lineOut.clkLevel == $past(linkSync))
    else $error("active link clock not following multiplier");

  start_delay_a: assert property (
    $rose(remote_sleep_out_n) |-> $past(startCnt_r) == 3'(`SLSS_REMOTE_SLEEP_OUT_N_EDGES - 1) && $past(pixRise))
    else $error("remote sleep raised at wrong edge");

  stop_delay_a: assert property (
    $fell(remote_sleep_out_n) |-> $past(stallCnt_r) == 7'(STOP_CYC)
      ##1 state_r == SLSS_OFF)
    else $error("remote sleep dropped at wrong time");

  off_quick_a: assert property (
    !sleepSync_n |=> (state_r == SLSS_OFF) && !lineOut.clkEn && !lineOut.dataEn && !pllEnable)
    else $error("power-down not reached in time");

  off_idle_a: assert property (
    (state_r == SLSS_OFF) |-> (lineOut == '0) && !linkActive)
    else $error("line driven in off phase");

  restart_lock_a: assert property (
    (state_r == SLSS_OFF) ##1 (state_r != SLSS_OFF) |-> (state_r == SLSS_LOCK) && (seqCnt_r == '0))
    else $error("restart skipped the lock wait");

endmodule

// ---- testbench/slss_far_end.sv ----
`timescale 1ns/1ps
module slss_far_end (
  input  wire logic                 mclk,
  input  wire logic                 reset_n,
  input  wire logic                 wakeIn,
  input  wire slss_pkg::slss_line_t lineIn,
  output logic                      calOk
);
  import slss_pkg::*;
  logic sawLow_r;
  // receive only: this end never drives the link, so no line current from here
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n || !wakeIn || !lineIn.clkEn) begin
      sawLow_r <= 1'h0;
      calOk    <= 1'h0;
    end else if (!lineIn.dataEn && !calOk) begin
      if (!lineIn.clkLevel)
        sawLow_r <= 1'h1;
      else if (sawLow_r)
        calOk <= 1'h1;
    end
  end
endmodule

// ---- testbench/test_serial_link_startup_sequencer.sv ----
`timescale 1ns/1ps
module test_serial_link_startup_sequencer;
  import slss_pkg::*;
  localparam int LOCK = 8;
  localparam int CAL  = 4;
  logic       mclk, reset_n, sleep_request_n, pixelClk, multLinkClk, pixRun;
  logic       remote_sleep_out_n, pllEnable, linkActive, calOk;
  logic [1:0] pixDiv;
  logic [7:0] lfsr;
  slss_line_t lineOut;
  int         fails, checks, pixCnt, linkCnt, lvlCnt;

  slss_sequencer #(.LOCK_EDGES(LOCK), .CAL_EDGES(CAL)) dut (
    .mclk(mclk), .reset_n(reset_n), .sleep_request_n(sleep_request_n),
    .pixelClk(pixelClk), .multLinkClk(multLinkClk), .lineOut(lineOut),
    .remote_sleep_out_n(remote_sleep_out_n), .pllEnable(pllEnable), .linkActive(linkActive));
  slss_far_end far (.mclk(mclk), .reset_n(reset_n), .wakeIn(remote_sleep_out_n),
    .lineIn(lineOut), .calOk(calOk));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end
  // odd offset keeps the link clock edges off the mclk edges
  initial begin
    multLinkClk = 1'h0;
    #13;
    forever #200 multLinkClk = ~multLinkClk;
  end
  always @(posedge mclk) begin
    #2;
    if (pixRun)
      pixDiv = pixDiv + 2'h1;
    pixelClk = pixDiv[1];
  end
  always @(posedge pixelClk) pixCnt++;
  always @(posedge multLinkClk) linkCnt++;
  always @(posedge lineOut.clkLevel) lvlCnt++;
  initial begin
    #500000;
    fails++;
    report_and_stop;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] nextRand(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic slss_line_t calLine(input int k);
    return (k == 1) ? 3'h2 : (k == 2) ? 3'h6 : 3'h3;
  endfunction
  function automatic logic reached(input int k);
    return (k == 0) ? pllEnable === 1'h1 : (k < 4) ? lineOut === calLine(k) : linkActive === 1'h1;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task automatic cmpVal(input logic [5:0] got, input logic [5:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmpRange(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic offChk;
    tick(4);
    cmpVal({pllEnable, linkActive, calOk, lineOut}, 6'h0);
  endtask
  task automatic pixStart;
    pixRun = 1'h1;
    repeat (6) @(posedge pixelClk);
    tick(2);
    cmpVal({5'h0, remote_sleep_out_n}, 6'h0);
    @(posedge pixelClk);
    tick(5);
    cmpVal({5'h0, remote_sleep_out_n}, 6'h1);
  endtask
  task automatic startUp;
    int n;
    for (int k = 0; k < 5; k++) begin
      n = 0;
      while (!reached(k) && n < 200) begin
        tick(1);
        n++;
      end
      cmpVal({5'h0, reached(k)}, 6'h1);
      if (k == 1)
        cmpRange(pixCnt, LOCK - 1, LOCK + 1);
      if (k > 1)
        cmpRange(linkCnt, CAL - 1, CAL + 1);
      pixCnt = 0;
      linkCnt = 0;
    end
    cmpVal({pllEnable, calOk, lineOut[1:0], 2'h0}, 6'h3C);
    lvlCnt = 0;
    tick(64);
    cmpRange(lvlCnt, 7, 9);
  endtask
  task automatic report_and_stop;
    if (fails == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'h0;
    sleep_request_n = 1'h1;
    pixRun = 1'h0;
    pixDiv = 2'h0;
    pixelClk = 1'h0;
    lfsr = 8'h3C;
    fails = 0;
    checks = 0;
    tick(20);
    reset_n = 1'h1;
    offChk;
    pixStart;
    startUp;
    // first pass aborts one cycle after release, the rest at random points
    for (int i = 0; i < 6; i++) begin
      lfsr = nextRand(lfsr);
      sleep_request_n = 1'h0;
      offChk;
      sleep_request_n = 1'h1;
      tick((i == 0) ? 1 : int'(lfsr) % 140);
      sleep_request_n = 1'h0;
      offChk;
      sleep_request_n = 1'h1;
      startUp;
    end
    pixRun = 1'h0;
    tick(66);
    cmpVal({5'h0, remote_sleep_out_n}, 6'h1);
    tick(12);
    cmpVal({remote_sleep_out_n, pllEnable, linkActive, lineOut}, 6'h0);
    pixStart;
    startUp;
    report_and_stop;
  end
endmodule
